// ---- rtl/mchp_consts.svh ----
`ifndef MCHP_CONSTS_SVH
`define MCHP_CONSTS_SVH
// host i/o port addresses
`define MCHP_ADDR_DATA 10'h2fc
`define MCHP_ADDR_RST_CLR 10'h2fd
`define MCHP_ADDR_CMD_STAT 10'h2fe
`define MCHP_ADDR_RST_SET 10'h2ff
// status bit positions
`define MCHP_ST_OBF 0
`define MCHP_ST_IBF 1
`define MCHP_ST_SPARE 2
`define MCHP_ST_CMD 3
`define MCHP_ST_BTN_LO 4
`define MCHP_ST_PWR 7
// command headers and lengths (header included)
`define MCHP_HDR_SET_TIME 8'h01
`define MCHP_HDR_READ_TIME 8'h02
`define MCHP_HDR_MOTION 8'h08
`define MCHP_HDR_TIMER 8'h20
`define MCHP_LEN_SET_TIME 4'h5
`define MCHP_LEN_READ_TIME 4'h1
`define MCHP_LEN_MOTION 4'h3
`define MCHP_LEN_TIMER 4'h2
// packet headers sent to the host
`define MCHP_PKT_A 8'h41
`define MCHP_PKT_B 8'h42
`define MCHP_PKT_M 8'h4d
`define MCHP_PKT_R 8'h52
// data bytes that follow an A, M or R header
`define MCHP_PKT_DATA 3'h4
// timer interval for timed packets, about 40 per second
`define MCHP_TIMER_PERIOD_NS 25000000
`define MCHP_CLK_PERIOD_NS 25
`define MCHP_TIMER_CYCLES (`MCHP_TIMER_PERIOD_NS / `MCHP_CLK_PERIOD_NS)
`endif

// ---- rtl/mchp_pkg.sv ----
package mchp_pkg;
  // controller processing states, gray coded along the cycle
  typedef enum logic [2:0] {
    MCHP_IDLE = 3'b000,
    MCHP_CHECK = 3'b001,
    MCHP_EXEC = 3'b011,
    MCHP_FLUSH = 3'b010,
    MCHP_SEND = 3'b110
  } mchp_state_t;
  // transfer modes toward the host
  typedef enum logic [1:0] {
    MCHP_MODE_EVERY = 2'b00,
    MCHP_MODE_FIRST = 2'b01,
    MCHP_MODE_POLL = 2'b10
  } mchp_mode_t;
endpackage : mchp_pkg

// ---- rtl/mchp_fifo.sv ----
`timescale 1ns/1ps
module mchp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest flags straight from the occupancy count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset, pointers do
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : mchp_fifo

// ---- rtl/mchp_port.sv ----
`timescale 1ns/1ps
`include "mchp_consts.svh"
// What this block does
// - select asserted on host read or write to data or command/status port
// - select forced off while the dma cycle flag is high
// - controller clock is bus oscillator divided by two in a flip-flop
// - controller reset is system reset or latch; set-reset port write sets latch
// - clear-reset port write clears latch unless system reset still asserted
// - data-ready signalled on irq line three by toggling output bit four
// - status bit 0 shows output full, bit 1 shows input full
// - command/status write stores byte and sets command flag; data write leaves it
// - status bits 4..6 show three buttons, 1 = released; bit 2 unused
// - status bit 7 set after clock chip reports low battery
// - set-time header 01 then minutes, hours, day, month in bcd
// - read-time header 02, no data, answered by R packet
// - motion header 08: 0 disables, 1..255 count gives M; buttons give B
// - timer header 20 one byte: nonzero sends A packets about 40 per second while motion is pending
// - each host write moves byte into input buffer and counts it, up to five bytes
// - on command flag check header and count; mismatch flushes buffer and flag
// - after a valid command flush pointer, counter and command flag
// - three host transfer modes: per-byte irq, first-byte irq, poll only
// - motion counted in 1/80 inch units per axis, reset when an A, M or R packet enters the fifo
// - output load sets output full, and irq per transfer mode; repeats irq while still full except in poll mode
module mchp_port
  import mchp_pkg::*;
#(
  parameter int TIMER_CYCLES = `MCHP_TIMER_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic SYS_RESET,
  input wire logic [9:0] ADDR,
  input wire logic DMA_CYCLE_FLAG,
  input wire logic IOR_N,
  input wire logic IOW_N,
  input wire logic [7:0] DATA_IN,
  input wire logic [1:0] MODE,
  input wire logic [2:0] BUTTONS_UP,
  input wire logic [3:0] MOUSE_INPUT_PORT_BITS,
  input wire logic LOW_BATTERY_SIGNAL,
  input wire logic [31:0] CLOCK_TIME,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic CHIP_SELECT,
  output logic CTRL_CLK,
  output logic CTRL_RESET,
  output logic IRQ_LINE_THREE,
  output logic [31:0] SET_TIME_DATA,
  output logic SET_TIME_STROBE
);
  localparam int TW = $clog2(TIMER_CYCLES + 1);

  logic [9:0] addr;
  logic rd_req;
  logic wr_req;
  logic sel_data;
  logic sel_cmd;
  logic cs;
  logic rd_q;
  logic wr_q;
  logic rd_edge;
  logic wr_edge;
  logic clk_div_q;
  logic rst_latch_q;
  logic ctl_rst;
  logic [7:0] in_reg_q;
  logic ibf_q;
  logic cmd_flag_q;
  logic [7:0] ibuf_q [5];
  logic [3:0] cnt_q;
  logic [7:0] out_reg_q;
  logic obf_q;
  logic irq_q;
  logic [2:0] pkt_pos_q;
  logic f_out_hdr;
  logic pwr_fail_q;
  logic [2:0] btn_q;
  logic [7:0] motion_lim_q;
  logic button_en_q;
  logic timer_en_q;
  logic [TW-1:0] tmr_q;
  logic [3:0] quad_q;
  logic signed [15:0] dx_q;
  logic signed [15:0] dy_q;
  logic [7:0] net_q;
  mchp_state_t state_q;
  logic [7:0] f_in;
  logic f_in_valid;
  logic f_in_ready;
  logic [7:0] f_out;
  logic f_out_valid;
  logic f_out_ready;
  logic [7:0] q_data_q [5];
  logic [2:0] q_len_q;
  logic [2:0] q_idx_q;
  logic cmd_ok;
  logic tmr_hit;

  // one quadrature step from old and new phase pair
  function automatic logic [1:0] quad_step(input logic [1:0] o, input logic [1:0] n);
    logic [1:0] r;
    r = 2'b00;
    if ({o, n} == 4'b0001 || {o, n} == 4'b0111 || {o, n} == 4'b1110 || {o, n} == 4'b1000) begin
      r = 2'b01;
    end else if ({o, n} == 4'b0010 || {o, n} == 4'b1011 || {o, n} == 4'b1101 ||
                 {o, n} == 4'b0100) begin
      r = 2'b11;
    end
    return r;
  endfunction : quad_step

  // header to command length, zero when unknown
  function automatic logic [3:0] cmd_len(input logic [7:0] h);
    logic [3:0] l;
    case (h)
      `MCHP_HDR_SET_TIME: l = `MCHP_LEN_SET_TIME;
      `MCHP_HDR_READ_TIME: l = `MCHP_LEN_READ_TIME;
      `MCHP_HDR_MOTION: l = `MCHP_LEN_MOTION;
      `MCHP_HDR_TIMER: l = `MCHP_LEN_TIMER;
      default: l = 4'h0;
    endcase
    return l;
  endfunction : cmd_len

  function automatic logic [7:0] abs8(input logic signed [15:0] v);
    logic [15:0] a;
    a = v[15] ? 16'(-v) : v;
    return (a > 16'h00ff) ? 8'hff : a[7:0];
  endfunction : abs8

  // address decode, dma cycles never select
  assign addr = ADDR;
  assign sel_data = (addr == `MCHP_ADDR_DATA);
  assign sel_cmd = (addr == `MCHP_ADDR_CMD_STAT);
  assign rd_req = !IOR_N;
  assign wr_req = !IOW_N;
  assign cs = (sel_data || sel_cmd) && (rd_req || wr_req) && !DMA_CYCLE_FLAG;
  assign rd_edge = rd_req && !rd_q && !DMA_CYCLE_FLAG;
  assign wr_edge = wr_req && !wr_q && !DMA_CYCLE_FLAG;
  assign ctl_rst = SYS_RESET || rst_latch_q;

  // strobe edge memory so one access acts once
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      CHIP_SELECT <= 1'b0;
    end else begin
      rd_q <= rd_req;
      wr_q <= wr_req;
      CHIP_SELECT <= cs;
    end
  end

  // controller clock divider
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      clk_div_q <= 1'b0;
    end else begin
      clk_div_q <= !clk_div_q;
    end
  end
  assign CTRL_CLK = clk_div_q;

  // reset latch; system reset holds it whatever the clear port says
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_latch_q <= 1'b0;
      CTRL_RESET <= 1'b1;
    end else begin
      if (wr_edge && addr == `MCHP_ADDR_RST_SET) begin
        rst_latch_q <= 1'b1;
      end else if (wr_edge && addr == `MCHP_ADDR_RST_CLR && !SYS_RESET) begin
        rst_latch_q <= 1'b0;
      end
      CTRL_RESET <= ctl_rst;
    end
  end

  // host write path into the input register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      in_reg_q <= 8'h00;
      ibf_q <= 1'b0;
      cmd_flag_q <= 1'b0;
    end else if (ctl_rst) begin
      ibf_q <= 1'b0;
      cmd_flag_q <= 1'b0;
    end else begin
      if (wr_edge && (sel_data || sel_cmd)) begin
        in_reg_q <= DATA_IN;
        ibf_q <= 1'b1;
      end else if (ibf_q && cnt_q < 4'd5) begin
        ibf_q <= 1'b0;
      end
      // a new command write wins over a flush in the same cycle
      if (wr_edge && sel_cmd) begin
        cmd_flag_q <= 1'b1;
      end else if (state_q == MCHP_FLUSH) begin
        cmd_flag_q <= 1'b0;
      end
    end
  end

  // input buffer and byte counter; overflow bytes stay pending as busy
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_q <= 4'h0;
      for (int i = 0; i < 5; i++) begin
        ibuf_q[i] <= 8'h00;
      end
    end else if (ctl_rst || state_q == MCHP_FLUSH) begin
      cnt_q <= 4'h0;
    end else if (ibf_q && !(wr_edge && (sel_data || sel_cmd)) && cnt_q < 4'd5) begin
      ibuf_q[cnt_q[2:0]] <= in_reg_q;
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // command checked only once the last byte is buffered
  assign cmd_ok = (cmd_len(ibuf_q[0]) != 4'h0) && (cmd_len(ibuf_q[0]) == cnt_q);

  // controller processing cycle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= MCHP_IDLE;
    end else if (ctl_rst) begin
      state_q <= MCHP_IDLE;
    end else begin
      case (state_q)
        MCHP_IDLE: if (cmd_flag_q && !ibf_q) state_q <= MCHP_CHECK;
        MCHP_CHECK: state_q <= cmd_ok ? MCHP_EXEC : MCHP_FLUSH;
        MCHP_EXEC: state_q <= MCHP_FLUSH;
        MCHP_FLUSH: state_q <= MCHP_IDLE;
        default: state_q <= MCHP_IDLE;
      endcase
    end
  end

  // command execution into settings
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      motion_lim_q <= 8'h00;
      button_en_q <= 1'b0;
      timer_en_q <= 1'b0;
      SET_TIME_DATA <= 32'h0;
      SET_TIME_STROBE <= 1'b0;
    end else if (ctl_rst) begin
      motion_lim_q <= 8'h00;
      button_en_q <= 1'b0;
      timer_en_q <= 1'b0;
      SET_TIME_STROBE <= 1'b0;
    end else begin
      SET_TIME_STROBE <= 1'b0;
      if (state_q == MCHP_EXEC) begin
        case (ibuf_q[0])
          `MCHP_HDR_SET_TIME: begin
            SET_TIME_DATA <= {ibuf_q[1], ibuf_q[2], ibuf_q[3], ibuf_q[4]};
            SET_TIME_STROBE <= 1'b1;
          end
          `MCHP_HDR_MOTION: begin
            motion_lim_q <= ibuf_q[1];
            button_en_q <= (ibuf_q[2] != 8'h00);
          end
          `MCHP_HDR_TIMER: timer_en_q <= (ibuf_q[1] != 8'h00);
          default: ;
        endcase
      end
    end
  end

  // low battery is sticky until a set-time command rechecks it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwr_fail_q <= 1'b0;
      btn_q <= 3'b111;
    end else begin
      btn_q <= BUTTONS_UP;
      if (LOW_BATTERY_SIGNAL) begin
        pwr_fail_q <= 1'b1;
      end else if (SET_TIME_STROBE) begin
        pwr_fail_q <= 1'b0;
      end
    end
  end

  // mickey accumulators, one count per quadrature edge
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      quad_q <= 4'h0;
      dx_q <= 16'sh0;
      dy_q <= 16'sh0;
    end else begin
      quad_q <= MOUSE_INPUT_PORT_BITS;
      if (f_in_valid && f_in_ready && q_idx_q == 3'd0 && q_len_q > 3'd1) begin
        dx_q <= 16'sh0;
        dy_q <= 16'sh0;
      end else begin
        dx_q <= dx_q + 16'(signed'(quad_step(quad_q[1:0], MOUSE_INPUT_PORT_BITS[1:0])));
        dy_q <= dy_q + 16'(signed'(quad_step(quad_q[3:2], MOUSE_INPUT_PORT_BITS[3:2])));
      end
    end
  end
  assign net_q = abs8(dx_q) > abs8(dy_q) ? abs8(dx_q) : abs8(dy_q);

  // timed packet interval
  assign tmr_hit = (tmr_q == TW'(TIMER_CYCLES - 1));
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_hit ? '0 : tmr_q + 1'b1;
    end
  end

  // packet builder feeds the fifo one byte at a time
  assign f_in_valid = (q_idx_q < q_len_q);
  assign f_in = q_data_q[q_idx_q];
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      q_len_q <= 3'd0;
      q_idx_q <= 3'd0;
      for (int i = 0; i < 5; i++) begin
        q_data_q[i] <= 8'h00;
      end
    end else if (f_in_valid) begin
      if (f_in_ready) begin
        q_idx_q <= q_idx_q + 3'd1;
      end
    end else begin
      q_idx_q <= 3'd0;
      q_len_q <= 3'd0;
      if (state_q == MCHP_EXEC && ibuf_q[0] == `MCHP_HDR_READ_TIME) begin
        q_data_q <= '{`MCHP_PKT_R, CLOCK_TIME[31:24], CLOCK_TIME[23:16],
                      CLOCK_TIME[15:8], CLOCK_TIME[7:0]};
        q_len_q <= 3'd5;
      end else if (motion_lim_q != 8'h00 && net_q >= motion_lim_q) begin
        q_data_q <= '{`MCHP_PKT_M, dx_q[15:8], dx_q[7:0], dy_q[15:8], dy_q[7:0]};
        q_len_q <= 3'd5;
      end else if (button_en_q && btn_q != BUTTONS_UP) begin
        q_data_q[0] <= `MCHP_PKT_B;
        q_len_q <= 3'd1;
      end else if (timer_en_q && tmr_hit && (dx_q != 16'sh0 || dy_q != 16'sh0)) begin
        q_data_q <= '{`MCHP_PKT_A, dx_q[15:8], dx_q[7:0], dy_q[15:8], dy_q[7:0]};
        q_len_q <= 3'd5;
      end
    end
  end

  // eight-byte buffer between packet builder and output register
  mchp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst_n(RSTN),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out)
  );
  // next byte withheld while the host has not read the last one
  assign f_out_ready = !obf_q && !ctl_rst;

  // position count, not byte value: a bcd 41 or 52 must not pass for a header
  assign f_out_hdr = (pkt_pos_q == 3'd0);

  // output register, full flag and irq toggle per transfer mode
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      out_reg_q <= 8'h00;
      obf_q <= 1'b0;
      irq_q <= 1'b0;
      pkt_pos_q <= 3'd0;
    end else begin
      if (f_out_valid && f_out_ready) begin
        out_reg_q <= f_out;
        obf_q <= 1'b1;
        if (!f_out_hdr) begin
          pkt_pos_q <= pkt_pos_q - 3'd1;
        end else if (f_out != `MCHP_PKT_B) begin
          pkt_pos_q <= `MCHP_PKT_DATA;
        end
        if (MODE == MCHP_MODE_EVERY) begin
          irq_q <= !irq_q;
        end else if (MODE == MCHP_MODE_FIRST && f_out_hdr) begin
          irq_q <= !irq_q;
        end
      end else if (rd_edge && sel_data) begin
        obf_q <= 1'b0;
      end else if (obf_q && tmr_hit && MODE != MCHP_MODE_POLL) begin
        irq_q <= !irq_q;
      end
    end
  end
  assign IRQ_LINE_THREE = irq_q;

  // read data back onto the bus
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      DATA_OUT <= 8'h00;
      DATA_OE <= 1'b0;
    end else begin
      DATA_OE <= rd_req && cs;
      if (sel_cmd) begin
        DATA_OUT <= {pwr_fail_q, btn_q, cmd_flag_q, 1'b0, ibf_q, obf_q};
      end else begin
        DATA_OUT <= out_reg_q;
      end
    end
  end
endmodule : mchp_port

// ---- testbench/mchp_port_chk.sv ----
`timescale 1ns/1ps
`include "mchp_consts.svh"
module mchp_port_chk
  import mchp_pkg::*;
#(
  parameter int TIMER_CYCLES = `MCHP_TIMER_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic SYS_RESET,
  input wire logic [9:0] ADDR,
  input wire logic DMA_CYCLE_FLAG,
  input wire logic IOR_N,
  input wire logic IOW_N,
  input wire logic [1:0] MODE,
  input wire logic [2:0] BUTTONS_UP,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE,
  input wire logic CHIP_SELECT,
  input wire logic CTRL_CLK,
  input wire logic CTRL_RESET,
  input wire logic IRQ_LINE_THREE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // raw port decode; the design registers it, so compare one cycle on
  logic port_hit;
  assign port_hit = (ADDR == `MCHP_ADDR_DATA || ADDR == `MCHP_ADDR_CMD_STAT)
    && !DMA_CYCLE_FLAG && (!IOR_N || !IOW_N);
  // a write is taken on the first edge that sees the strobe low
  sequence s_wr(a);
    $fell(IOW_N) && ADDR == a && !DMA_CYCLE_FLAG;
  endsequence
  // buttons settled while the controller runs
  sequence s_btn_settled;
    ($stable(BUTTONS_UP) && !CTRL_RESET)[*8];
  endsequence
  AST_CS_DECODE: assert property (1 |=> CHIP_SELECT == $past(port_hit))
    else $error("chip select does not follow the port decode");
  AST_OE_READ: assert property (port_hit && !IOR_N |=> DATA_OE)
    else $error("read of a board port not driven");
  AST_DMA_BLOCK: assert property (DMA_CYCLE_FLAG |=> !CHIP_SELECT && !DATA_OE)
    else $error("access selected during dma");
  AST_CLK_DIV: assert property (1 |=> CTRL_CLK != $past(CTRL_CLK))
    else $error("controller clock not half rate");
  AST_RST_SET: assert property (s_wr(`MCHP_ADDR_RST_SET) |-> ##[1:2] CTRL_RESET)
    else $error("set-reset write did not reset controller");
  AST_RST_SYS: assert property (SYS_RESET |=> CTRL_RESET)
    else $error("system reset not passed to controller");
  AST_RST_CLR: assert property (s_wr(`MCHP_ADDR_RST_CLR) ##0 !SYS_RESET
    |-> ##[1:2] !CTRL_RESET)
    else $error("clear-reset write did not release controller");
  AST_IRQ_POLL: assert property ((MODE == MCHP_MODE_POLL)[*3] |-> $stable(IRQ_LINE_THREE))
    else $error("interrupt moved in poll mode");
  AST_STAT_BTN: assert property (s_btn_settled ##0 DATA_OE && $past(ADDR) == `MCHP_ADDR_CMD_STAT
    |-> DATA_OUT[6:4] == BUTTONS_UP && !DATA_OUT[2])
    else $error("status button bits wrong");
endmodule : mchp_port_chk

bind mchp_port mchp_port_chk #(.TIMER_CYCLES(TIMER_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .CLK(CLK), .RSTN(RSTN), .SYS_RESET(SYS_RESET), .ADDR(ADDR), .DMA_CYCLE_FLAG(DMA_CYCLE_FLAG),
  .IOR_N(IOR_N), .IOW_N(IOW_N), .MODE(MODE), .BUTTONS_UP(BUTTONS_UP), .DATA_OUT(DATA_OUT),
  .DATA_OE(DATA_OE), .CHIP_SELECT(CHIP_SELECT), .CTRL_CLK(CTRL_CLK), .CTRL_RESET(CTRL_RESET),
  .IRQ_LINE_THREE(IRQ_LINE_THREE));

// ---- testbench/mchp_host_model.sv ----
`timescale 1ns/1ps
`include "mchp_consts.svh"
module mchp_host_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  output logic [9:0] addr,
  output logic ior_n,
  output logic iow_n,
  output logic dma,
  output logic [7:0] data_in
);
  int fails = 0;
  // idle bus at time zero
  initial begin
    addr = 10'h000;
    ior_n = 1'b1;
    iow_n = 1'b1;
    dma = 1'b0;
    data_in = 8'h00;
  end
  // strobe low for two edges so the low-after-high edge is seen
  task automatic io_wr(input logic [9:0] a, input logic [7:0] d, input logic dm = 1'b0);
    @(negedge clk);
    addr = a;
    data_in = d;
    dma = dm;
    iow_n = 1'b0;
    repeat (2) @(negedge clk);
    iow_n = 1'b1;
    dma = 1'b0;
    data_in = ~d; // released bus must not keep the byte
    @(negedge clk);
  endtask : io_wr
  task automatic io_rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    ior_n = 1'b0;
    repeat (2) @(negedge clk);
    d = data_out;
    ior_n = 1'b1;
    @(negedge clk);
  endtask : io_rd
  // bounded poll of input full; a stuck controller is reset (time scaled down)
  task automatic wait_ibf();
    logic [7:0] s;
    for (int i = 0; i < 50; i++) begin
      io_rd(`MCHP_ADDR_CMD_STAT, s);
      if (s[`MCHP_ST_IBF] === 1'b0) return;
    end
    fails++;
    io_wr(`MCHP_ADDR_RST_SET, 8'h00);
    io_wr(`MCHP_ADDR_RST_CLR, 8'h00);
  endtask : wait_ibf
  // earlier bytes to data port, last one to command port
  task automatic send_cmd(input logic [7:0] b [5], input int n);
    for (int i = 0; i < n; i++) begin
      wait_ibf();
      io_wr(i == n - 1 ? `MCHP_ADDR_CMD_STAT : `MCHP_ADDR_DATA, b[i]);
    end
  endtask : send_cmd
endmodule : mchp_host_model

// ---- testbench/mchp_port_tb.sv ----
`timescale 1ns/1ps
`include "mchp_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH at %0t: got %0h expected %0h", $time, g, e); end end
module mchp_port_tb;
  import mchp_pkg::*;
  localparam int TCYC = 50;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sys_reset = 1'b0;
  logic [1:0] mode = 2'b00;
  logic [2:0] buttons = 3'b111;
  logic [3:0] mouse_bits = 4'h0;
  logic low_bat = 1'b0;
  logic [31:0] clock_time = 32'h0;
  logic [9:0] addr;
  logic dma, ior_n, iow_n, data_oe, cs, ctrl_clk, ctrl_reset, irq, set_stb;
  logic [7:0] data_in, data_out;
  logic [31:0] set_data;
  int err_count = 0;
  int n_checks = 0;
  int irq_n = 0;
  int stb_n = 0;
  int cycles = 0;
  logic [7:0] c [5];
  logic [7:0] b, s;
  logic [7:0] t [4];
  always #12.5 clk = ~clk;
  mchp_host_model u_host (.clk(clk), .data_out(data_out), .addr(addr), .ior_n(ior_n),
    .iow_n(iow_n), .dma(dma), .data_in(data_in));
  mchp_port #(.TIMER_CYCLES(TCYC), .FIFO_DEPTH(8)) DUT (.CLK(clk), .RSTN(rstn),
    .SYS_RESET(sys_reset), .ADDR(addr), .DMA_CYCLE_FLAG(dma), .IOR_N(ior_n), .IOW_N(iow_n),
    .DATA_IN(data_in), .MODE(mode), .BUTTONS_UP(buttons), .MOUSE_INPUT_PORT_BITS(mouse_bits),
    .LOW_BATTERY_SIGNAL(low_bat), .CLOCK_TIME(clock_time), .DATA_OUT(data_out),
    .DATA_OE(data_oe), .CHIP_SELECT(cs), .CTRL_CLK(ctrl_clk), .CTRL_RESET(ctrl_reset),
    .IRQ_LINE_THREE(irq), .SET_TIME_DATA(set_data), .SET_TIME_STROBE(set_stb));
  // event counters and hang guard
  always @(posedge irq or negedge irq) irq_n++;
  always @(posedge set_stb) stb_n++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      finish_test();
    end
  end
  function automatic logic [7:0] rnd_bcd(input int lo, input int hi);
    int v;
    v = lo + $urandom_range(hi - lo);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : rnd_bcd
  // interrupts seen over one five-byte packet, per transfer mode
  function automatic logic irq_ok(input int m, input int n);
    return m == 2 ? n == 0 : n >= (m == 0 ? 5 : 1);
  endfunction : irq_ok
  // poll output full within a bound, then take the byte; X if none came
  task automatic get_byte(output logic [7:0] d, input int lim);
    d = 8'hxx;
    for (int i = 0; i < lim; i++) begin
      u_host.io_rd(`MCHP_ADDR_CMD_STAT, s);
      if (s[`MCHP_ST_OBF] === 1'b1) begin
        u_host.io_rd(`MCHP_ADDR_DATA, d);
        return;
      end
    end
  endtask : get_byte
  task automatic drain();
    repeat (6) get_byte(b, 30);
  endtask : drain
  task automatic finish_test();
    err_count += u_host.fails;
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(32'h5bd53e89));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    // reset latch, dma blanking and system reset
    u_host.io_wr(`MCHP_ADDR_RST_CLR, 8'h00);
    `CHK(ctrl_reset, 1'b0)
    u_host.io_wr(`MCHP_ADDR_RST_SET, 8'h5a);
    `CHK(ctrl_reset, 1'b1)
    u_host.io_wr(`MCHP_ADDR_RST_CLR, 8'h00, 1'b1);
    `CHK(ctrl_reset, 1'b1)
    sys_reset = 1'b1;
    u_host.io_wr(`MCHP_ADDR_RST_CLR, 8'h00);
    `CHK(ctrl_reset, 1'b1)
    sys_reset = 1'b0;
    u_host.io_wr(`MCHP_ADDR_RST_CLR, 8'h00);
    `CHK(ctrl_reset, 1'b0)
    // status bits with random buttons
    for (int i = 0; i < 4; i++) begin
      buttons = 3'($urandom);
      repeat (12) @(negedge clk);
      u_host.io_rd(`MCHP_ADDR_CMD_STAT, b);
      `CHK(b[6:4], buttons)
      `CHK(b[3:0], 4'h0)
    end
    low_bat = 1'b1;
    repeat (8) @(negedge clk);
    low_bat = 1'b0;
    u_host.io_rd(`MCHP_ADDR_CMD_STAT, b);
    `CHK(b[`MCHP_ST_PWR], 1'b1)
    // set time, which also clears the power-fail flag
    t = '{rnd_bcd(0, 59), rnd_bcd(0, 23), rnd_bcd(1, 28), rnd_bcd(1, 12)};
    c = '{`MCHP_HDR_SET_TIME, t[0], t[1], t[2], t[3]};
    u_host.send_cmd(c, 5);
    for (int i = 0; i < 400 && stb_n == 0; i++) @(negedge clk);
    `CHK(stb_n, 1)
    `CHK(set_data, {t[0], t[1], t[2], t[3]})
    u_host.wait_ibf();
    u_host.io_rd(`MCHP_ADDR_CMD_STAT, b);
    `CHK(b[`MCHP_ST_PWR], 1'b0)
    // short set time and unknown header are flushed without effect
    c = '{`MCHP_HDR_SET_TIME, 8'h12, 8'h00, 8'h00, 8'h00};
    u_host.send_cmd(c, 2);
    // a data-port byte is buffered but raises no command flag
    u_host.wait_ibf();
    u_host.io_wr(`MCHP_ADDR_DATA, 8'h55);
    u_host.io_rd(`MCHP_ADDR_CMD_STAT, b);
    `CHK(b[3:1], 3'b000)
    c = '{8'h55, 8'h00, 8'h00, 8'h00, 8'h00};
    u_host.send_cmd(c, 1);
    repeat (100) @(negedge clk);
    u_host.io_rd(`MCHP_ADDR_CMD_STAT, b);
    `CHK(stb_n, 1)
    `CHK(b[3:0], 4'h0)
    // read time in each transfer mode
    for (int m = 0; m < 3; m++) begin
      mode = 2'(m);
      clock_time = {rnd_bcd(0, 59), rnd_bcd(0, 23), rnd_bcd(1, 28), rnd_bcd(1, 12)};
      irq_n = 0;
      c = '{`MCHP_HDR_READ_TIME, 8'h00, 8'h00, 8'h00, 8'h00};
      u_host.send_cmd(c, 1);
      get_byte(b, 100);
      `CHK(b, `MCHP_PKT_R)
      for (int i = 0; i < 4; i++) begin
        get_byte(b, 100);
        `CHK(b, clock_time[31 - 8 * i -: 8])
      end
      `CHK(irq_ok(m, irq_n), 1'b1)
      u_host.io_rd(`MCHP_ADDR_CMD_STAT, b);
      `CHK(b[`MCHP_ST_OBF], 1'b0)
    end
    // one quadrature step with motion threshold one
    mode = 2'b00;
    c = '{`MCHP_HDR_MOTION, 8'h01, 8'h00, 8'h00, 8'h00};
    u_host.send_cmd(c, 3);
    repeat (20) @(negedge clk);
    mouse_bits = 4'h1;
    get_byte(b, 100);
    `CHK(b, `MCHP_PKT_M)
    for (int i = 0; i < 4; i++) get_byte(t[i], 100);
    `CHK({t[0], t[1]} == 16'h0001 || {t[0], t[1]} == 16'hffff, 1'b1)
    `CHK({t[2], t[3]}, 16'h0000)
    // motion off, buttons on: a button change gives a B packet
    c = '{`MCHP_HDR_MOTION, 8'h00, 8'h01, 8'h00, 8'h00};
    u_host.send_cmd(c, 3);
    repeat (10) @(negedge clk);
    buttons = ~buttons;
    get_byte(b, 100);
    `CHK(b, `MCHP_PKT_B)
    c[2] = 8'h00;
    u_host.send_cmd(c, 3);
    drain();
    // timed packet once motion is pending
    mouse_bits = 4'h3;
    c = '{`MCHP_HDR_TIMER, 8'h01, 8'h00, 8'h00, 8'h00};
    u_host.send_cmd(c, 2);
    get_byte(b, 200);
    `CHK(b, `MCHP_PKT_A)
    c = '{`MCHP_HDR_TIMER, 8'h00, 8'h00, 8'h00, 8'h00};
    drain();
    u_host.send_cmd(c, 2);
    drain();
    finish_test();
  end
endmodule : mchp_port_tb
